// >>> spi_flash_pkg.sv
package spi_flash_pkg;

  // ****************************************************************
  // Command opcodes.
  // ****************************************************************
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
  localparam logic [7:0] OP_ERASE_32K_B = 8'hd8;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_NONE = 8'h00;

  // ****************************************************************
  // Array geometry.
  // ****************************************************************
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] BLOCK_4K_MASK = 16'hf000;
  localparam logic [15:0] BLOCK_32K_MASK = 16'h8000;
  localparam logic [2:0] ADDR_DONE_BYTES = 3'h4;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int BYTE_PROGRAM_TIME_US = 20;
  localparam int PAGE_PROGRAM_TIME_US = 1000;
  localparam int BLOCK_ERASE_TIME_US = 50000;
  localparam int BYTE_PROGRAM_CYCLES = BYTE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Status word bit positions and pin synchroniser lanes.
  // ****************************************************************
  localparam int STAT_BUSY = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_BP = 2;
  localparam int STAT_ERR = 5;
  localparam int LANE_SCK = 0;
  localparam int LANE_CS = 1;
  localparam int LANE_MOSI = 2;
  localparam logic [2:0] SYNC_RESET = 3'h2;

  typedef enum logic [1:0] {PH_IDLE, PH_SCAN, PH_ERASE_REQ, PH_WAIT} phase_t;
  typedef enum logic [1:0] {OPK_BYTE, OPK_PAGE, OPK_ERASE} op_kind_t;

  typedef struct packed {
    logic erase;
    logic big;
    logic [15:0] addr;
    logic [7:0] data;
  } fifo_entry_t;

endpackage

// >>> spi_flash_program_erase.sv
`timescale 1ns/100ps
module spi_flash_program_erase
  import spi_flash_pkg::*;
#(
  parameter int PAGE_CYCLES = PAGE_PROGRAM_CYCLES,
  parameter int ERASE_CYCLES = BLOCK_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  input wire logic blockProtectBit,
  input wire logic arrayVerifyFail,
  output logic arrValid,
  input wire logic arrReady,
  output logic arrErase,
  output logic arrBlock32,
  output logic [15:0] arrAddr,
  output logic [7:0] arrData,
  output logic busy,
  output logic writeEnableLatch,
  output logic programEraseErrorFlag,
  output logic [7:0] statusWord
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] f;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] ptr;
    logic [1:0] dataCnt;
    logic [255:0] loaded;
    logic frameIgnore;
    logic write_enable_latch;
    logic err;
    phase_t phase;
    op_kind_t kind;
    logic big;
    logic [8:0] scanIdx;
    logic [31:0] timer;
    logic timerDone;
    fifo_entry_t [1:0] ent;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] cnt;
  } state_t;

  state_t q_q;
  state_t q_d;
  logic [7:0] pageBuf [PAGE_BYTES];
  logic bufWrite;
  logic [7:0] shiftNext;
  logic sckRise;
  logic csFall;
  logic csRise;
  logic abortEvt;
  logic weEvt;
  logic push;
  logic pop;
  logic isErase;
  logic aligned;
  logic addrDone;
  fifo_entry_t pushEnt;
  logic [31:0] limit;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    q_d = q_q;
    bufWrite = 1'b0;
    abortEvt = 1'b0;
    weEvt = 1'b0;
    push = 1'b0;
    pushEnt = '0;
    // Pins pass three flops; a change counts once the last two agree.
    // The filtered copy only moves on agreement, so a pin that glitches for a
    // single cycle never produces a false edge on the serial clock.
    q_d.s1 = {spiMosi, spiCsN, spiClk};
    q_d.s2 = q_q.s1;
    q_d.s3 = q_q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q_q.s2[i] == q_q.s3[i]) begin
        q_d.f[i] = q_q.s3[i];
      end
    end
    sckRise = (q_q.s2[LANE_SCK] == q_q.s3[LANE_SCK]) && q_q.s3[LANE_SCK] && !q_q.f[LANE_SCK];
    csFall = (q_q.s2[LANE_CS] == q_q.s3[LANE_CS]) && !q_q.s3[LANE_CS] && q_q.f[LANE_CS];
    csRise = (q_q.s2[LANE_CS] == q_q.s3[LANE_CS]) && q_q.s3[LANE_CS] && !q_q.f[LANE_CS];
    shiftNext = {q_q.shift[6:0], q_q.s3[LANE_MOSI]};
    isErase = (q_q.opcode == OP_ERASE_4K) || (q_q.opcode == OP_ERASE_32K_A) ||
              (q_q.opcode == OP_ERASE_32K_B);
    aligned = (q_q.bitCnt == 3'h0);
    addrDone = (q_q.byteCnt == ADDR_DONE_BYTES);

    // Serial frame capture; frames that start while busy are ignored.
    // The page buffer is only cleared by a frame that starts while idle, so the
    // scan of a running program never sees its loaded marks disappear.
    if (csFall) begin
      q_d.frameIgnore = (q_q.phase != PH_IDLE);
      q_d.bitCnt = 3'h0;
      q_d.byteCnt = 3'h0;
      q_d.opcode = OP_NONE;
      if (q_q.phase == PH_IDLE) begin
        q_d.dataCnt = 2'h0;
        q_d.loaded = '0;
      end
    end else if (sckRise && !q_q.f[LANE_CS] && !q_q.frameIgnore) begin
      q_d.shift = shiftNext;
      q_d.bitCnt = q_q.bitCnt + 3'h1;
      if (q_q.bitCnt == 3'h7) begin
        if (!addrDone) begin
          q_d.byteCnt = q_q.byteCnt + 3'h1;
        end
        case (q_q.byteCnt)
          3'h0: q_d.opcode = shiftNext;
          3'h1: ;
          3'h2: q_d.addr[15:8] = shiftNext;
          3'h3: begin
            q_d.addr[7:0] = shiftNext;
            q_d.ptr = shiftNext;
          end
          default: begin
            // The pointer wraps inside the page, so a long frame overwrites the
            // oldest bytes and only the last page of data survives.
            if (q_q.opcode == OP_PROGRAM) begin
              bufWrite = 1'b1;
              q_d.loaded[q_q.ptr] = 1'b1;
              q_d.ptr = q_q.ptr + 8'h1;
              if (q_q.dataCnt != 2'h2) begin
                q_d.dataCnt = q_q.dataCnt + 2'h1;
              end
            end
          end
        endcase
      end
    end

    // Decision on release of chip select.
    // A release with the latch clear is no abort: the latch is already clear
    // and nothing else changes.
    if (csRise && !q_q.frameIgnore && q_q.phase == PH_IDLE) begin
      if (q_q.opcode == OP_WRITE_ENABLE && aligned) begin
        weEvt = 1'b1;
        q_d.write_enable_latch = 1'b1;
      end else if (q_q.opcode == OP_PROGRAM && q_q.write_enable_latch) begin
        if (blockProtectBit || !addrDone || q_q.dataCnt == 2'h0 || !aligned) begin
          abortEvt = 1'b1;
          q_d.write_enable_latch = 1'b0;
        end else begin
          q_d.write_enable_latch = 1'b0;
          q_d.err = 1'b0;
          q_d.phase = PH_SCAN;
          q_d.kind = (q_q.dataCnt == 2'h1) ? OPK_BYTE : OPK_PAGE;
          q_d.scanIdx = 9'h0;
          q_d.timer = 32'h0;
          q_d.timerDone = 1'b0;
        end
      end else if (isErase && q_q.write_enable_latch) begin
        if (blockProtectBit || !addrDone || !aligned) begin
          abortEvt = 1'b1;
          q_d.write_enable_latch = 1'b0;
        end else begin
          q_d.write_enable_latch = 1'b0;
          q_d.err = 1'b0;
          q_d.phase = PH_ERASE_REQ;
          q_d.kind = OPK_ERASE;
          q_d.big = (q_q.opcode != OP_ERASE_4K);
          q_d.timer = 32'h0;
          q_d.timerDone = 1'b0;
        end
      end
    end
    if (csRise) begin
      q_d.frameIgnore = 1'b0;
    end

    // Self-timed operation.
    // The timer runs from the accepted release, independent of how fast the
    // array takes words, and busy waits for both the timer and a drained buffer.
    case (q_q.kind)
      OPK_BYTE: limit = 32'(BYTE_PROGRAM_CYCLES);
      OPK_PAGE: limit = 32'(PAGE_CYCLES);
      default: limit = 32'(ERASE_CYCLES);
    endcase
    if (q_q.phase != PH_IDLE && !q_q.timerDone) begin
      q_d.timer = q_q.timer + 32'h1;
      q_d.timerDone = (q_q.timer == limit - 32'h1);
    end
    case (q_q.phase)
      PH_SCAN: begin
        if (q_q.scanIdx[8]) begin
          q_d.phase = PH_WAIT;
        end else if (!q_q.loaded[q_q.scanIdx[7:0]]) begin
          q_d.scanIdx = q_q.scanIdx + 9'h1;
        end else if (q_q.cnt != 2'h2) begin
          push = 1'b1;
          pushEnt = '{erase: 1'b0, big: 1'b0, addr: {q_q.addr[15:8], q_q.scanIdx[7:0]},
                      data: pageBuf[q_q.scanIdx[7:0]]};
          q_d.scanIdx = q_q.scanIdx + 9'h1;
        end
      end
      PH_ERASE_REQ: begin
        if (q_q.cnt != 2'h2) begin
          push = 1'b1;
          pushEnt = '{erase: 1'b1, big: q_q.big,
                      addr: q_q.addr & (q_q.big ? BLOCK_32K_MASK : BLOCK_4K_MASK), data: ERASED_BYTE};
          q_d.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (q_q.timerDone && q_q.cnt == 2'h0) begin
          q_d.phase = PH_IDLE;
        end
      end
      default: ;
    endcase
    if (arrayVerifyFail && q_q.phase != PH_IDLE) begin
      q_d.err = 1'b1;
    end

    // Two-entry buffer towards the array.
    // The scan stalls while both entries are taken, so a slow array loses no word.
    pop = (q_q.cnt != 2'h0) && arrReady;
    if (push) begin
      q_d.ent[q_q.wrPtr] = pushEnt;
      q_d.wrPtr = !q_q.wrPtr;
    end
    if (pop) begin
      q_d.rdPtr = !q_q.rdPtr;
    end
    q_d.cnt = q_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_q <= '{s1: SYNC_RESET, s2: SYNC_RESET, s3: SYNC_RESET, f: SYNC_RESET,
               opcode: OP_NONE, phase: PH_IDLE, kind: OPK_BYTE, default: '0};
    end else begin
      q_q <= q_d;
    end
  end

  always_ff @(posedge clk) begin
    if (bufWrite) begin
      pageBuf[q_q.ptr] <= shiftNext;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign arrValid = (q_q.cnt != 2'h0);
  assign arrErase = q_q.ent[q_q.rdPtr].erase;
  assign arrBlock32 = q_q.ent[q_q.rdPtr].big;
  assign arrAddr = q_q.ent[q_q.rdPtr].addr;
  assign arrData = q_q.ent[q_q.rdPtr].data;
  assign busy = (q_q.phase != PH_IDLE);
  assign writeEnableLatch = q_q.write_enable_latch;
  assign programEraseErrorFlag = q_q.err;

  always_comb begin
    statusWord = 8'h00;
    statusWord[STAT_BUSY] = busy;
    statusWord[STAT_WEL] = q_q.write_enable_latch;
    statusWord[STAT_BP] = blockProtectBit;
    statusWord[STAT_ERR] = q_q.err;
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_start_clears_latch: assert property ($rose(busy) |-> !writeEnableLatch)
    else $error("latch still set after operation start");
  chk_start_needs_latch: assert property ($rose(busy) |-> $past(writeEnableLatch))
    else $error("operation started without latch");
  chk_protect_blocks_start: assert property ($rose(busy) |-> !$past(blockProtectBit))
    else $error("operation started while protected");
  chk_abort_clears_latch: assert property (abortEvt |=> !writeEnableLatch && !busy)
    else $error("abort left latch set or started work");
  chk_program_has_data: assert property ($rose(busy) && q_q.kind != OPK_ERASE |-> $past(q_q.dataCnt) != 2'h0)
    else $error("program started with no data byte");
  chk_single_byte_time: assert property ($rose(busy) && q_q.kind == OPK_BYTE |-> q_q.loaded != '0)
    else $error("byte program without a loaded byte");
  chk_wrap_in_page: assert property (arrValid && !arrErase |-> arrAddr[15:8] == q_q.addr[15:8])
    else $error("program address left the page");
  chk_erase_block_align: assert property (arrValid && arrErase && arrBlock32 |-> arrAddr[14:0] == 15'h0)
    else $error("32K erase address not aligned");
  chk_fault_sets_error: assert property (arrayVerifyFail && busy |=> programEraseErrorFlag)
    else $error("verify failure not flagged");
  chk_stall_holds_word: assert property (arrValid && !arrReady |=> arrValid && $stable(arrAddr) && $stable(arrData))
    else $error("buffer word lost under stall");
  chk_enable_sets_latch: assert property (weEvt |=> writeEnableLatch [*2])
    else $error("write enable did not set latch");

  // Timing choice, erase decode and status holding.
  // Some watch the internal state at the start or end of an operation; the rest are checked on every cycle.
  chk_byte_time_one: assert property ($rose(busy) && q_q.kind == OPK_BYTE |-> $past(q_q.dataCnt) == 2'h1)
    else $error("byte time chosen without exactly one byte");
  chk_finish_drained: assert property ($fell(busy) |-> $past(q_q.timerDone) && $past(q_q.cnt) == 2'h0)
    else $error("operation ended before timer or drain");
  chk_erase_data_ff: assert property (arrValid && arrErase |-> arrData == ERASED_BYTE)
    else $error("erase word does not carry erased value");
  chk_busy_no_latch: assert property (busy |-> !writeEnableLatch)
    else $error("latch set while busy");
  chk_error_sticky: assert property (programEraseErrorFlag ##1 !$rose(busy) |-> programEraseErrorFlag)
    else $error("error flag dropped without a new start");
  chk_scan_loaded: assert property (arrValid && !arrErase |-> q_q.loaded[arrAddr[7:0]])
    else $error("program word for an unloaded location");
  chk_erase_size_decode: assert property ($rose(busy) && q_q.kind == OPK_ERASE |->
                                          q_q.big == ($past(q_q.opcode) != OP_ERASE_4K))
    else $error("erase size does not match opcode");
  chk_erase_4k_align: assert property (arrValid && arrErase && !arrBlock32 |-> arrAddr[11:0] == 12'h000)
    else $error("4K erase address not aligned");
  chk_stall_holds_kind: assert property (arrValid && !arrReady |=> $stable(arrErase) && $stable(arrBlock32))
    else $error("buffer kind changed under stall");

  // ****************************************************************
  // Cover points.
  // ****************************************************************

  cov_program_run: cover property ($rose(busy) && q_q.kind == OPK_PAGE);
  cov_erase_run: cover property ($rose(busy) && q_q.kind == OPK_ERASE);
  cov_stall: cover property (arrValid && !arrReady && q_q.cnt == 2'h2);
  cov_abort: cover property (abortEvt);
  cov_byte_run: cover property ($rose(busy) && q_q.kind == OPK_BYTE);

endmodule

// >>> flash_array_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Array side: takes words and stalls one cycle in four.
// ****************************************************************
module flash_array_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic arrValid,
  output logic arrReady,
  input wire logic arrErase,
  input wire logic arrBlock32,
  input wire logic [15:0] arrAddr,
  input wire logic [7:0] arrData
);
  logic [25:0] words[$];
  logic [1:0] cnt_q;
  assign arrReady = cnt_q != 2'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (arrValid && arrReady) begin
        words.push_back({arrErase, arrBlock32, arrAddr, arrData});
      end
    end
  end
endmodule

// >>> spi_flash_program_erase_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module spi_flash_program_erase_tb;
  import spi_flash_pkg::*;
  logic clk, resetn, spiClk, spiCsN, spiMosi, blockProtectBit, arrayVerifyFail;
  logic arrValid, arrReady, arrErase, arrBlock32, busy, writeEnableLatch, programEraseErrorFlag;
  logic [15:0] arrAddr;
  logic [7:0] arrData, statusWord;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic cpol = 1'b0;
  logic [7:0] eop[3] = '{8'h20, 8'h52, 8'hd8};
  logic [23:0] ead[3] = '{24'h001234, 24'h009abc, 24'h007fff};
  logic [15:0] eex[3] = '{16'h1000, 16'h8000, 16'h0000};

  spi_flash_program_erase #(.PAGE_CYCLES(300), .ERASE_CYCLES(500)) spi_flash_program_erase_i (
    .clk(clk), .resetn(resetn), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .blockProtectBit(blockProtectBit), .arrayVerifyFail(arrayVerifyFail), .arrValid(arrValid),
    .arrReady(arrReady), .arrErase(arrErase), .arrBlock32(arrBlock32), .arrAddr(arrAddr),
    .arrData(arrData), .busy(busy), .writeEnableLatch(writeEnableLatch),
    .programEraseErrorFlag(programEraseErrorFlag), .statusWord(statusWord));
  flash_array_model flash_array_model_i (
    .clk(clk), .resetn(resetn), .arrValid(arrValid), .arrReady(arrReady), .arrErase(arrErase),
    .arrBlock32(arrBlock32), .arrAddr(arrAddr), .arrData(arrData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Sends the low n bits of v MSB first in mode 0 or 3 (idle clock level cpol).
  task automatic spi(input logic [63:0] v, input int n);
    spiClk = cpol;
    tick(4);
    spiCsN = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      spiClk = 1'b0;
      spiMosi = v[n - 1 - i];
      tick(4);
      spiClk = 1'b1;
      tick(4);
    end
    spiClk = cpol;
    tick(4);
    spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    tick(8);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) begin
      tick(1);
    end
    `CHK("idle", 1'b0, busy)
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    resetn = 1'b0;
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
    blockProtectBit = 1'b0;
    arrayVerifyFail = 1'b0;
    tick(8);
    resetn = 1'b1;
    tick(4);
    // ****************************************************************
    // Program without the latch, then a wrapping three-byte program.
    // ****************************************************************
    spi({8'h02, 24'h0000fe, 8'haa}, 40);
    `CHK("nolatch busy", 1'b0, busy)
    spi(8'h06, 8);
    `CHK("latch set", 1'b1, writeEnableLatch)
    spi({8'h02, 24'h0000fe, 8'haa, 8'hbb, 8'hcc}, 56);
    `CHK("prog busy", 8'h01, statusWord)
    wait_idle();
    `CHK("prog count", 3, flash_array_model_i.words.size())
    `CHK("wrap", {2'b00, 16'h0000, 8'hcc}, flash_array_model_i.words[0])
    `CHK("first", {2'b00, 16'h00fe, 8'haa}, flash_array_model_i.words[1])
    `CHK("second", {2'b00, 16'h00ff, 8'hbb}, flash_array_model_i.words[2])
    flash_array_model_i.words.delete();
    // ****************************************************************
    // Single byte uses the longer byte time.
    // ****************************************************************
    spi(8'h06, 8);
    spi({8'h02, 24'h000310, 8'h5a}, 40);
    tick(1000);
    `CHK("byte time", 1'b1, busy)
    wait_idle();
    `CHK("byte word", {2'b00, 16'h0310, 8'h5a}, flash_array_model_i.words[0])
    flash_array_model_i.words.delete();
    // ****************************************************************
    // Aborts: partial data byte, short erase address, protected array.
    // ****************************************************************
    spi(8'h06, 8);
    spi({8'h02, 24'h000100, 8'h77} >> 3, 37);
    `CHK("partial latch", 1'b0, writeEnableLatch)
    spi(8'h06, 8);
    spi({8'h20, 16'h0012}, 24);
    `CHK("short latch", 1'b0, writeEnableLatch)
    spi(8'h06, 8);
    blockProtectBit = 1'b1;
    spi({8'h20, 24'h001000}, 32);
    `CHK("prot status", 8'h04, statusWord)
    spi(8'h06, 8);
    spi({8'h02, 24'h000000, 8'h11}, 40);
    `CHK("prot prog", 8'h04, statusWord)
    blockProtectBit = 1'b0;
    `CHK("no words", 0, flash_array_model_i.words.size())
    // ****************************************************************
    // Every erase opcode, with ignored low bits and a trailing byte.
    // ****************************************************************
    for (int i = 0; i < 3; i++) begin
      cpol = (i == 2);
      spi(8'h06, 8);
      spi({eop[i], ead[i], 8'h55}, 40);
      `CHK("erase start", 8'h01, statusWord)
      if (i == 0) begin
        arrayVerifyFail = 1'b1;
        tick(1);
        arrayVerifyFail = 1'b0;
        tick(1);
        `CHK("erase error", 8'h21, statusWord)
        `CHK("error flag", 1'b1, programEraseErrorFlag)
      end
      wait_idle();
      `CHK("erase count", 1, flash_array_model_i.words.size())
      `CHK("erase word", {1'b1, i != 0, eex[i], 8'hff}, flash_array_model_i.words[0])
      flash_array_model_i.words.delete();
    end
    test_done();
  end
endmodule
